// ==== rtl/bus_b_upper_regs.vh ====
// constants for the second-bus upper module colour select register
// assumes: included once per design file, 50 MHz system clock
`ifndef BUS_B_UPPER_REGS_VH
`define BUS_B_UPPER_REGS_VH
`define SEL_REG_OFFSET      8'h0C
`define SEL_REG_RESET       8'h00
`define EN3_BIT             7
`define PICK3_HI            6
`define PICK3_LO            4
`define EN4_BIT             3
`define PICK4_HI            2
`define PICK4_LO            0
// multiplex cycle: 50 MHz / 23 kHz = 2173 cycles, quarter = 543
`define MUX_FREQ_HZ         23000
`define CLK_FREQ_HZ         50000000
`define QUARTER_CYCLES      (`CLK_FREQ_HZ / (`MUX_FREQ_HZ * 4))
`define QUARTER_LAST        10'h021E
`define FADE_STEP_LAST      10'h00FF
`define CUR_ZERO            8'h00
`define CUR_ONE             8'h01
`endif

// ==== rtl/current_fader.v ====
// one channel fade engine: ramps current toward target one step per tick
// assumes: tick is a one-cycle enable from the same clock
`default_nettype none
module current_fader
(
   input  wire       i_clk,
   input  wire       i_rst_b,
   input  wire       i_tick,
   input  wire [7:0] i_target,
   output reg  [7:0] o_level
);
`include "bus_b_upper_regs.vh"
   // step one lsb toward the target on each tick
   always @(posedge i_clk or negedge i_rst_b)
   begin
      if (!i_rst_b)
         o_level <= `CUR_ZERO;
      else if (i_tick && (o_level < i_target))
         o_level <= o_level + `CUR_ONE;
      else if (i_tick && (o_level > i_target))
         o_level <= o_level - `CUR_ONE;
   end
endmodule // current_fader
`default_nettype wire

// ==== rtl/bus_b_upper_colour_select.v ====
// colour select register for anode 3 and 4 modules of the second bus,
// anode scan timing and per-channel fading of the selected currents
// assumes: register port driven synchronously by the serial bus slave;
// current sets come from other registers as plain inputs
`default_nettype none
`include "bus_b_upper_regs.vh"
// Contract
// [RQ1] bit 7 enables anode-3 module, else fade zero
// [RQ2] bits 6:4 pick red/green/blue sets, anode 3
// [RQ3] bit 3 enables anode-4 module, else fade zero
// [RQ4] bits 2:0 pick red/green/blue sets, anode 4
// [RQ5] anodes scanned each quarter, about 23 kHz
// [RQ6] reset clears enables and picks to zero
// [RQ7] register changes ramp currents through fade engines
module bus_b_upper_colour_select
(
   input  wire       I_CLK_SYS,
   input  wire       I_RST_B,
   input  wire [7:0] I_REG_ADDR,
   input  wire       I_REG_WR,
   input  wire       I_REG_RD,
   input  wire [7:0] I_REG_WDATA,
   input  wire [7:0] I_RED_SET_ZERO,
   input  wire [7:0] I_RED_SET_ONE,
   input  wire [7:0] I_GREEN_SET_ZERO,
   input  wire [7:0] I_GREEN_SET_ONE,
   input  wire [7:0] I_BLUE_SET_ZERO,
   input  wire [7:0] I_BLUE_SET_ONE,
   output reg  [7:0] O_REG_RDATA,
   output reg        O_REG_HIT,
   output reg  [3:0] O_ANODE_ACTIVE,
   output reg  [7:0] O_LINE_1_CURRENT,
   output reg  [7:0] O_LINE_2_CURRENT,
   output reg  [7:0] O_LINE_3_CURRENT,
   output reg  [7:0] O_LINE_4_CURRENT
);
   reg        rst_meta_reg;     // reset release stage 1
   reg        rst_sync_reg;     // released reset used by logic
   reg  [7:0] sel_reg;          // the colour select register
   reg  [9:0] quarter_cnt_reg;  // cycles within one anode slot
   reg  [1:0] anode_reg;        // anode currently driven
   reg  [9:0] fade_cnt_reg;     // fade tick divider
   reg        fade_tick_reg;    // one-cycle fade enable
   reg  [7:0] t3 [0:2];         // anode-3 targets r,g,b
   reg  [7:0] t4 [0:2];         // anode-4 targets r,g,b
   wire [7:0] lvl3 [0:2];       // faded anode-3 levels
   wire [7:0] lvl4 [0:2];       // faded anode-4 levels
   wire       en3 = sel_reg[`EN3_BIT];
   wire       en4 = sel_reg[`EN4_BIT];
   wire [2:0] pick3 = sel_reg[`PICK3_HI:`PICK3_LO];
   wire [2:0] pick4 = sel_reg[`PICK4_HI:`PICK4_LO];

   // reset released through two flops
   // entry is immediate, exit waits for clock edges so that no flop
   // sees its reset lift too close to the edge that clocks it
   always @(posedge I_CLK_SYS or negedge I_RST_B)
   begin
      // pin low: whole block held in reset
      if (!I_RST_B)
      begin
         rst_meta_reg <= 1'b0;
         rst_sync_reg <= 1'b0;
      end
      // pin high: shift a one through the pair
      else
      begin
         rst_meta_reg <= 1'b1;
         rst_sync_reg <= rst_meta_reg;
      end
   end

   // register write and read port
   // one access per strobe cycle; answer shows one cycle later
   always @(posedge I_CLK_SYS or negedge rst_sync_reg)
   begin
      // both modules off, every colour on set zero
      if (!rst_sync_reg)
      begin
         sel_reg     <= `SEL_REG_RESET; // see [RQ6]
         O_REG_RDATA <= 8'h00;
         O_REG_HIT   <= 1'b0;
      end
      else
      begin
         // hit pulses only for an access to our own address
         O_REG_HIT <= (I_REG_WR || I_REG_RD) && (I_REG_ADDR == `SEL_REG_OFFSET);
         // writes to other addresses leave the register alone
         // a read in the cycle of a write still returns the old value
         if (I_REG_WR && (I_REG_ADDR == `SEL_REG_OFFSET))
            sel_reg <= I_REG_WDATA;
         // unmapped reads answer zero
         if (I_REG_RD && (I_REG_ADDR == `SEL_REG_OFFSET))
            O_REG_RDATA <= sel_reg;
         else if (I_REG_RD)
            O_REG_RDATA <= 8'h00;
      end
   end

   // fade targets from enable and palette pick
   // a disabled module gets target zero, so it fades out, never cuts off
   // each pick bit chooses set zero or set one of its own colour
   always @*
   begin
      // anode 3: bit6 red, bit5 green, bit4 blue
      t3[0] = !en3 ? `CUR_ZERO : (pick3[2] ? I_RED_SET_ONE : I_RED_SET_ZERO);     // see [RQ1]
      t3[1] = !en3 ? `CUR_ZERO : (pick3[1] ? I_GREEN_SET_ONE : I_GREEN_SET_ZERO); // see [RQ2]
      t3[2] = !en3 ? `CUR_ZERO : (pick3[0] ? I_BLUE_SET_ONE : I_BLUE_SET_ZERO);   // see [RQ2]
      // anode 4: bit2 red, bit1 green, bit0 blue
      // same sets, different cathode lines than anode 3
      t4[0] = !en4 ? `CUR_ZERO : (pick4[2] ? I_RED_SET_ONE : I_RED_SET_ZERO);     // see [RQ3]
      t4[1] = !en4 ? `CUR_ZERO : (pick4[1] ? I_GREEN_SET_ONE : I_GREEN_SET_ZERO); // see [RQ4]
      t4[2] = !en4 ? `CUR_ZERO : (pick4[0] ? I_BLUE_SET_ONE : I_BLUE_SET_ZERO);   // see [RQ4]
   end

   // fade tick divider
   // one tick per wrap of the counter; each tick moves a channel one lsb
   // free running, so the first step after a write may come early
   always @(posedge I_CLK_SYS or negedge rst_sync_reg)
   begin
      // divider idle in reset
      if (!rst_sync_reg)
      begin
         fade_cnt_reg  <= 10'h0000;
         fade_tick_reg <= 1'b0;
      end
      // count, pulse the tick on the last count
      else
      begin
         fade_tick_reg <= (fade_cnt_reg == `FADE_STEP_LAST);
         fade_cnt_reg  <= (fade_cnt_reg == `FADE_STEP_LAST) ? 10'h0000 : fade_cnt_reg + 10'h0001;
      end
   end

   // six fade engines, one per channel
   genvar g;
   generate
      for (g = 0; g < 3; g = g + 1)
      begin : g_fade
         current_fader u_f3 // see [RQ7]
         (
            .i_clk    (I_CLK_SYS),
            .i_rst_b  (rst_sync_reg),
            .i_tick   (fade_tick_reg),
            .i_target (t3[g]),
            .o_level  (lvl3[g])
         );
         current_fader u_f4 // see [RQ7]
         (
            .i_clk    (I_CLK_SYS),
            .i_rst_b  (rst_sync_reg),
            .i_tick   (fade_tick_reg),
            .i_target (t4[g]),
            .o_level  (lvl4[g])
         );
      end
   endgenerate

   // anode scan: each anode one quarter of the cycle
   // four equal slots make up one multiplex cycle
   always @(posedge I_CLK_SYS or negedge rst_sync_reg)
   begin
      // scan starts on anode 1
      if (!rst_sync_reg)
      begin
         quarter_cnt_reg <= 10'h0000;
         anode_reg       <= 2'b00;
      end
      // end of slot: next anode, index wraps from 4 to 1
      else if (quarter_cnt_reg == `QUARTER_LAST) // see [RQ5]
      begin
         quarter_cnt_reg <= 10'h0000;
         anode_reg       <= anode_reg + 2'b01;
      end
      // inside the slot
      else
         quarter_cnt_reg <= quarter_cnt_reg + 10'h0001;
   end

   // line currents while anode 3 or 4 is active
   // anode and line outputs change on the same edge, one cycle after
   // the slot index, so no line carries current into the wrong slot
   always @(posedge I_CLK_SYS or negedge rst_sync_reg)
   begin
      // no anode and no current while in reset
      if (!rst_sync_reg)
      begin
         O_ANODE_ACTIVE   <= 4'h0;
         O_LINE_1_CURRENT <= 8'h00;
         O_LINE_2_CURRENT <= 8'h00;
         O_LINE_3_CURRENT <= 8'h00;
         O_LINE_4_CURRENT <= 8'h00;
      end
      else
      begin
         O_ANODE_ACTIVE <= 4'h1 << anode_reg; // see [RQ5]
         case (anode_reg)
            2'b10:
            begin
               // anode 3: red line1, green line4, blue line2
               O_LINE_1_CURRENT <= lvl3[0];
               O_LINE_4_CURRENT <= lvl3[1];
               O_LINE_2_CURRENT <= lvl3[2];
               O_LINE_3_CURRENT <= 8'h00;
            end
            2'b11:
            begin
               // anode 4: red line2, green line1, blue line3
               O_LINE_2_CURRENT <= lvl4[0];
               O_LINE_1_CURRENT <= lvl4[1];
               O_LINE_3_CURRENT <= lvl4[2];
               O_LINE_4_CURRENT <= 8'h00;
            end
            default:
            begin
               // anodes 1 and 2 belong to another register
               O_LINE_1_CURRENT <= 8'h00;
               O_LINE_2_CURRENT <= 8'h00;
               O_LINE_3_CURRENT <= 8'h00;
               O_LINE_4_CURRENT <= 8'h00;
            end
         endcase
      end
   end
endmodule // bus_b_upper_colour_select
`default_nettype wire

// ==== dv/host_model.sv ====
// host model: issues register strobes toward the select block
// assumes: strobes change 1 ns after a rising edge of i_clk
`default_nettype none
module host_model (
   input  wire logic       i_clk,
   input  wire logic [7:0] i_rdata,
   input  wire logic       i_hit,
   output var  logic [7:0] o_addr,
   output var  logic       o_wr,
   output var  logic       o_rd,
   output var  logic [7:0] o_wdata
);
   timeunit 1ns;
   timeprecision 1ps;
   // idle bus, no strobe
   initial
   begin
      o_addr = 8'hFF;
      o_wr = 1'b0;
      o_rd = 1'b0;
      o_wdata = 8'h00;
   end
   // one strobe cycle, answer taken one edge later
   task automatic access(input logic w, input logic [7:0] a, d,
                         output logic [7:0] q, output logic h);
      @(posedge i_clk);
      #1;
      o_addr = a;
      o_wdata = d;
      o_wr = w;
      o_rd = !w;
      @(posedge i_clk);
      #1;
      q = i_rdata;
      h = i_hit;
      o_wr = 1'b0;
      o_rd = 1'b0;
      o_addr = 8'hFF;
      o_wdata = ~d;
   endtask
endmodule // host_model
`default_nettype wire

// ==== dv/colour_select_asserts.sv ====
// checker for the select block, bound to its top ports
// assumes: one clock domain, active-low asynchronous reset
`default_nettype none
module colour_select_asserts (
   input wire logic       I_CLK_SYS,
   input wire logic       I_RST_B,
   input wire logic [7:0] I_REG_ADDR,
   input wire logic       I_REG_WR,
   input wire logic       I_REG_RD,
   input wire logic [7:0] O_REG_RDATA,
   input wire logic       O_REG_HIT,
   input wire logic [3:0] O_ANODE_ACTIVE,
   input wire logic [7:0] O_LINE_1_CURRENT,
   input wire logic [7:0] O_LINE_2_CURRENT
);
   default clocking cb @(posedge I_CLK_SYS); endclocking
   default disable iff (!I_RST_B);
   a_hit_on_write: assert property (I_REG_WR && I_REG_ADDR == 8'h0C |=> O_REG_HIT)
      else $error("no hit after write");
   a_miss_read: assert property (I_REG_RD && !I_REG_WR && I_REG_ADDR != 8'h0C
      |=> !O_REG_HIT && O_REG_RDATA == 8'h00) else $error("unmapped read answered");
   a_one_slot: assert property ($onehot0(O_ANODE_ACTIVE))
      else $error("more than one anode");
   a_slot_length: assert property ($rose(O_ANODE_ACTIVE[2])
      |-> ##[543:543] $rose(O_ANODE_ACTIVE[3])) else $error("slot length wrong");
   a_slot_order: assert property ($fell(O_ANODE_ACTIVE[3]) |-> O_ANODE_ACTIVE[0])
      else $error("scan order wrong");
   a_idle_lines: assert property (O_ANODE_ACTIVE[0] && $past(O_ANODE_ACTIVE[0])
      |-> O_LINE_1_CURRENT == 8'h00 && O_LINE_2_CURRENT == 8'h00) else $error("idle current");
   a_fade_step: assert property (O_ANODE_ACTIVE[2] && $past(O_ANODE_ACTIVE[2], 2)
      |-> 8'(O_LINE_1_CURRENT - $past(O_LINE_1_CURRENT)) inside {8'h00, 8'h01, 8'hFF})
      else $error("current stepped");
   a_reset_clear: assert property (disable iff (1'b0) !I_RST_B
      |-> O_ANODE_ACTIVE == 4'h0 && !O_REG_HIT) else $error("outputs live in reset");
   c_write: cover property (I_REG_WR && I_REG_ADDR == 8'h0C);
   c_slot4: cover property ($rose(O_ANODE_ACTIVE[3]));
   c_lit: cover property (O_ANODE_ACTIVE[2] && O_LINE_1_CURRENT != 8'h00);
endmodule // colour_select_asserts
bind bus_b_upper_colour_select colour_select_asserts i_chk (.I_CLK_SYS, .I_RST_B,
   .I_REG_ADDR, .I_REG_WR, .I_REG_RD, .O_REG_RDATA, .O_REG_HIT, .O_ANODE_ACTIVE,
   .O_LINE_1_CURRENT, .O_LINE_2_CURRENT);
`default_nettype wire

// ==== dv/test_bus_b_upper_colour_select.sv ====
// bench for the second-bus upper module colour select block
// assumes: host model and checker compiled first, 50 MHz clock
`default_nettype none
module test_bus_b_upper_colour_select;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 1'b0;
   logic rst_b = 1'b1;
   logic [7:0] addr, wdata, rdata, q, l1, l2, l3, l4;
   logic wr, rd, hit, h;
   logic [3:0] act;
   logic [7:0] cur [6] = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06};
   int n_fail = 0;
   int n_checks = 0;
   int cyc = 0;
   initial forever #10 clk = ~clk;
   host_model i_host (.i_clk(clk), .i_rdata(rdata), .i_hit(hit), .o_addr(addr),
      .o_wr(wr), .o_rd(rd), .o_wdata(wdata));
   bus_b_upper_colour_select i_dut (.I_CLK_SYS(clk), .I_RST_B(rst_b), .I_REG_ADDR(addr),
      .I_REG_WR(wr), .I_REG_RD(rd), .I_REG_WDATA(wdata), .I_RED_SET_ZERO(cur[0]),
      .I_RED_SET_ONE(cur[1]), .I_GREEN_SET_ZERO(cur[2]), .I_GREEN_SET_ONE(cur[3]),
      .I_BLUE_SET_ZERO(cur[4]), .I_BLUE_SET_ONE(cur[5]), .O_REG_RDATA(rdata),
      .O_REG_HIT(hit), .O_ANODE_ACTIVE(act), .O_LINE_1_CURRENT(l1),
      .O_LINE_2_CURRENT(l2), .O_LINE_3_CURRENT(l3), .O_LINE_4_CURRENT(l4));
   task automatic chk(string name, logic [7:0] seen, logic [7:0] exp);
      n_checks++;
      if (seen !== exp)
      begin
         n_fail++;
         $display("Error %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic end_sim();
      $display("checks %0d mismatches %0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   // hang guard
   always @(posedge clk)
   begin
      cyc++;
      if (cyc == 70000)
      begin
         n_fail++;
         end_sim();
      end
   end
   // settle fades, then sit inside anode slot k
   task automatic in_slot(input int k);
      repeat (4000) @(posedge clk);
      for (int i = 0; i < 3000 && act[k] !== 1'b1; i++)
         @(posedge clk);
      repeat (20) @(posedge clk);
      #1;
   endtask
   task automatic t_access();
      i_host.access(1'b0, 8'h0C, 8'h00, q, h);
      chk("reset value", q, 8'h00);
      i_host.access(1'b1, 8'h0C, 8'h88, q, h);
      chk("write hit", {7'h00, h}, 8'h01);
      i_host.access(1'b0, 8'h0C, 8'h00, q, h);
      chk("readback", q, 8'h88);
      i_host.access(1'b0, 8'h0D, 8'h00, q, h);
      chk("unmapped data", q, 8'h00);
      chk("unmapped hit", {7'h00, h}, 8'h00);
   endtask
   task automatic t_anode3();
      i_host.access(1'b1, 8'h0C, 8'hD5, q, h);
      in_slot(2);
      chk("a3 red", l1, 8'h02);
      chk("a3 green", l4, 8'h03);
      chk("a3 blue", l2, 8'h06);
      in_slot(3);
      chk("a4 off", l1 | l2 | l3, 8'h00);
   endtask
   task automatic t_anode4();
      i_host.access(1'b1, 8'h0C, 8'h3A, q, h);
      in_slot(3);
      chk("a4 red", l2, 8'h01);
      chk("a4 green", l1, 8'h04);
      chk("a4 blue", l3, 8'h05);
      in_slot(2);
      chk("a3 off", l1 | l2 | l4, 8'h00);
   endtask
   // anode-3 red ramps toward a large set value, one lsb per fade tick
   task automatic t_fade();
      cur[1] = 8'h40;
      i_host.access(1'b1, 8'h0C, 8'hC0, q, h);
      for (int i = 0; i < 3000 && act[3] !== 1'b1; i++)
         @(posedge clk);
      for (int i = 0; i < 3000 && act[2] !== 1'b1; i++)
         @(posedge clk);
      repeat (20) @(posedge clk);
      #1;
      chk("fade partway", {7'h00, (l1 > 8'h00) && (l1 < 8'h40)}, 8'h01);
      repeat (13000) @(posedge clk);
      in_slot(2);
      chk("fade done", l1, 8'h40);
   endtask
   initial
   begin
      #1 rst_b = 1'b0;
      repeat (8) @(posedge clk);
      #1 rst_b = 1'b1;
      repeat (4) @(posedge clk);
      t_access();
      t_anode3();
      t_anode4();
      t_fade();
      end_sim();
   end
endmodule // test_bus_b_upper_colour_select
`default_nettype wire
